// File: core/soa_cfg.svh
// offsets, field positions, reset values and timing counts of the stream offset block
`ifndef SOA_CFG_SVH
`define SOA_CFG_SVH
`define SOA_OFS_IN_DELAY0 8'h03
`define SOA_IN_DELAY_REGS 6
`define SOA_OFS_MEASURE 8'h09
`define SOA_OFS_ADV_LOW 8'h0A
`define SOA_OFS_ADV_HIGH 8'h0B
`define SOA_OFS_ACCESS 8'h0C
`define SOA_OFS_WDATA 8'h0D
`define SOA_OFS_RDATA 8'h0E
`define SOA_BIT_DONE 14
`define SOA_BIT_RD_REQ 13
`define SOA_BIT_WR_REQ 12
`define SOA_CH_HI 11
`define SOA_CH_LO 5
`define SOA_ST_HI 4
`define SOA_ST_LO 0
`define SOA_MEAS_SEL_HI 15
`define SOA_MEAS_SEL_LO 11
`define SOA_BIT_HALF 9
`define SOA_RST_REG 16'h0000
`define SOA_XFER_NS 10
`define SOA_CLK_NS 10
`define SOA_XFER_CYCLES ((`SOA_XFER_NS + `SOA_CLK_NS - 1) / `SOA_CLK_NS)
`endif

// File: core/soa_pkg.sv
// types shared by the stream offset and indirect access block
package soa_pkg;
    typedef enum logic [0:0] {SOA_IDLE = 1'b0, SOA_BUSY = 1'b1} soa_state_t;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [15:0] wdata;
    } soa_bus_t;
endpackage

// File: core/soa_stream_offset.sv
// stream input offset, output advance and indirect memory access registers
`timescale 1ns/1ps
`default_nettype none
`include "soa_cfg.svh"
// Notes on behaviour
// - input sampled after offset whole clock periods, plus half when latch edge set.
// - measurement reads half flag 0 when half period present, plus whole count.
// - reset gives zero shift; measurement reads half flag 1, count 0.
// - output advance bit 1 launches first bit half a clock early.
// - low advance register serves streams 0-15, high bits 7-0 streams 16-23.
// - both advance registers reset to zero, at addresses 0A and 0B.
// - done flag bit 14 is read only, sets when a transfer completes.
// - done flag clears when software takes a request bit from 1 to 0.
// - read request rising starts memory to read data; self-clears on done.
// - write request rising starts write data to memory; self-clears on done.
// - channel select bits 11-5 pick the channel within the memory subsection.
// - stream select bits 4-0 pick the stream subsection of memory.
// - offset bits set the wait from frame pulse before storing bit 0.
module soa_stream_offset #(
    parameter int N_STREAMS = 24,
    parameter int N_CHANNELS = 128
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port pins
    input wire soa_pkg::soa_bus_t bus_pins,
    output logic [15:0] bus_rdata,
    output logic bus_rdata_oe,
    // serial timing and stream pins
    input wire logic serial_clk,
    input wire logic frame_pulse_in_n,
    input wire logic [N_STREAMS-1:0] serial_stream_pin,
    // per stream results
    output logic [N_STREAMS-1:0] bit0_data,
    output logic [N_STREAMS-1:0] bit0_valid,
    output logic [N_STREAMS-1:0] out_launch
);
    import soa_pkg::*;
    localparam int DEPTH = N_STREAMS * N_CHANNELS;
    localparam int IW = $clog2(DEPTH);
    // ==========================================
    // pin synchronisers
    soa_bus_t bus_s1_reg, bus_s2_reg, bus_s3_reg;
    logic [N_STREAMS+1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_s1_reg <= '1;
            bus_s2_reg <= '1;
            bus_s3_reg <= '1;
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            pin_s3_reg <= '1;
        end
        else
        begin
            bus_s1_reg <= bus_pins;
            bus_s2_reg <= bus_s1_reg;
            bus_s3_reg <= bus_s2_reg;
            pin_s1_reg <= {serial_clk, frame_pulse_in_n, serial_stream_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end
    logic sclk_rise, sclk_fall, fp_low, wr_take, rd_active;
    logic [N_STREAMS-1:0] data_s;
    assign sclk_rise = pin_s2_reg[N_STREAMS+1] & ~pin_s3_reg[N_STREAMS+1];
    assign sclk_fall = ~pin_s2_reg[N_STREAMS+1] & pin_s3_reg[N_STREAMS+1];
    assign fp_low = ~pin_s2_reg[N_STREAMS];
    assign data_s = pin_s2_reg[N_STREAMS-1:0];
    // write taken once per strobe, on its falling edge
    assign wr_take = ~bus_s2_reg.cs_n & ~bus_s2_reg.wr_n & bus_s3_reg.wr_n;
    assign rd_active = ~bus_s2_reg.cs_n & ~bus_s2_reg.rd_n;
    // ==========================================
    // register file
    logic [15:0] in_delay_reg [0:`SOA_IN_DELAY_REGS-1];
    logic [15:0] in_delay_next [0:`SOA_IN_DELAY_REGS-1];
    logic [15:0] adv_low_reg, adv_low_next, adv_high_reg, adv_high_next;
    logic [15:0] access_reg, access_next, wdata_reg, wdata_next;
    logic [15:0] rdata_reg, rdata_next, bus_rdata_reg, bus_rdata_next;
    logic [4:0] meas_sel_reg, meas_sel_next;
    logic rdata_oe_reg;
    soa_state_t state_reg, state_next;
    logic [15:0] mem_reg [0:DEPTH-1];
    logic [IW-1:0] mem_idx;
    logic idx_ok, done_set, mem_we;
    logic [15:0] meas_word;
    logic [3:0] sel_nib;
    logic [N_STREAMS-1:0] adv_bits;
    assign mem_idx = IW'(32'(access_reg[`SOA_ST_HI:`SOA_ST_LO]) * N_CHANNELS
                        + 32'(access_reg[`SOA_CH_HI:`SOA_CH_LO]));
    assign idx_ok = 32'(access_reg[`SOA_ST_HI:`SOA_ST_LO]) < N_STREAMS
                    && 32'(access_reg[`SOA_CH_HI:`SOA_CH_LO]) < N_CHANNELS;
    assign done_set = (state_reg == SOA_BUSY);
    assign mem_we = done_set & access_reg[`SOA_BIT_WR_REQ] & idx_ok;
    assign adv_bits = N_STREAMS'({adv_high_reg[7:0], adv_low_reg});
    assign sel_nib = 4'(in_delay_reg[meas_sel_reg[4:2] < 3'(`SOA_IN_DELAY_REGS) ?
        meas_sel_reg[4:2] : 3'h0] >> {meas_sel_reg[1:0], 2'h0});
    assign meas_word = {meas_sel_reg, 1'b0, ~sel_nib[0], 6'h00, sel_nib[3:1]};
    always_comb
    begin
        for (int i = 0; i < `SOA_IN_DELAY_REGS; i++)
            in_delay_next[i] = in_delay_reg[i];
        adv_low_next = adv_low_reg;
        adv_high_next = adv_high_reg;
        access_next = access_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        meas_sel_next = meas_sel_reg;
        state_next = state_reg;
        if (wr_take)
        begin
            if (bus_s2_reg.addr >= `SOA_OFS_IN_DELAY0 &&
                bus_s2_reg.addr < `SOA_OFS_IN_DELAY0 + 8'(`SOA_IN_DELAY_REGS))
                in_delay_next[3'(bus_s2_reg.addr - `SOA_OFS_IN_DELAY0)] = bus_s2_reg.wdata;
            else if (bus_s2_reg.addr == `SOA_OFS_MEASURE)
                meas_sel_next = bus_s2_reg.wdata[`SOA_MEAS_SEL_HI:`SOA_MEAS_SEL_LO];
            // advance registers at 0A and 0B
            else if (bus_s2_reg.addr == `SOA_OFS_ADV_LOW)
                adv_low_next = bus_s2_reg.wdata;
            else if (bus_s2_reg.addr == `SOA_OFS_ADV_HIGH)
                adv_high_next = bus_s2_reg.wdata;
            else if (bus_s2_reg.addr == `SOA_OFS_WDATA)
                wdata_next = bus_s2_reg.wdata;
            else if (bus_s2_reg.addr == `SOA_OFS_ACCESS)
            begin
                access_next = {1'b0, access_reg[`SOA_BIT_DONE], bus_s2_reg.wdata[13:0]};
                // request dropped by software clears done
                if ((access_reg[`SOA_BIT_RD_REQ] & ~bus_s2_reg.wdata[`SOA_BIT_RD_REQ]) |
                    (access_reg[`SOA_BIT_WR_REQ] & ~bus_s2_reg.wdata[`SOA_BIT_WR_REQ]) |
                    ~(|bus_s2_reg.wdata[`SOA_BIT_RD_REQ:`SOA_BIT_WR_REQ]))
                    access_next[`SOA_BIT_DONE] = 1'b0;
                if (state_reg == SOA_IDLE &&
                    ((~access_reg[`SOA_BIT_RD_REQ] & bus_s2_reg.wdata[`SOA_BIT_RD_REQ]) |
                     (~access_reg[`SOA_BIT_WR_REQ] & bus_s2_reg.wdata[`SOA_BIT_WR_REQ])))
                    state_next = SOA_BUSY;
            end
        end
        case (state_reg)
            SOA_IDLE: state_next = state_next;
            SOA_BUSY:
            begin
                if (access_reg[`SOA_BIT_RD_REQ])
                    rdata_next = idx_ok ? mem_reg[mem_idx] : `SOA_RST_REG;
                // done wins over a clear, requests self-clear
                access_next[`SOA_BIT_DONE] = 1'b1;
                access_next[`SOA_BIT_RD_REQ] = 1'b0;
                access_next[`SOA_BIT_WR_REQ] = 1'b0;
                state_next = SOA_IDLE;
            end
            default: state_next = SOA_IDLE;
        endcase
        bus_rdata_next = bus_rdata_reg;
        if (rd_active)
        begin
            if (bus_s2_reg.addr >= `SOA_OFS_IN_DELAY0 &&
                bus_s2_reg.addr < `SOA_OFS_IN_DELAY0 + 8'(`SOA_IN_DELAY_REGS))
                bus_rdata_next = in_delay_reg[3'(bus_s2_reg.addr - `SOA_OFS_IN_DELAY0)];
            else if (bus_s2_reg.addr == `SOA_OFS_MEASURE)
                bus_rdata_next = meas_word;
            else if (bus_s2_reg.addr == `SOA_OFS_ADV_LOW)
                bus_rdata_next = adv_low_reg;
            else if (bus_s2_reg.addr == `SOA_OFS_ADV_HIGH)
                bus_rdata_next = adv_high_reg;
            else if (bus_s2_reg.addr == `SOA_OFS_ACCESS)
                bus_rdata_next = access_reg;
            else if (bus_s2_reg.addr == `SOA_OFS_WDATA)
                bus_rdata_next = wdata_reg;
            else if (bus_s2_reg.addr == `SOA_OFS_RDATA)
                bus_rdata_next = rdata_reg;
            else
                bus_rdata_next = `SOA_RST_REG;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < `SOA_IN_DELAY_REGS; i++)
                in_delay_reg[i] <= `SOA_RST_REG;
            adv_low_reg <= `SOA_RST_REG;
            adv_high_reg <= `SOA_RST_REG;
            access_reg <= `SOA_RST_REG;
            wdata_reg <= `SOA_RST_REG;
            rdata_reg <= `SOA_RST_REG;
            bus_rdata_reg <= `SOA_RST_REG;
            meas_sel_reg <= 5'h00;
            rdata_oe_reg <= 1'b0;
            state_reg <= SOA_IDLE;
        end
        else
        begin
            for (int i = 0; i < `SOA_IN_DELAY_REGS; i++)
                in_delay_reg[i] <= in_delay_next[i];
            adv_low_reg <= adv_low_next;
            adv_high_reg <= adv_high_next;
            access_reg <= access_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            bus_rdata_reg <= bus_rdata_next;
            meas_sel_reg <= meas_sel_next;
            rdata_oe_reg <= rd_active;
            state_reg <= state_next;
        end
    end
    // memory has no reset: too many flops to clear, software loads it
    // write data into memory
    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
            mem_reg[mem_idx] <= wdata_reg;
    end
    assign bus_rdata = bus_rdata_reg;
    assign bus_rdata_oe = rdata_oe_reg;
    // ==========================================
    // frame reference
    logic fp_seen_reg, fp_seen_next, frame_ref;
    assign frame_ref = sclk_rise & fp_seen_reg;
    always_comb
    begin
        fp_seen_next = fp_seen_reg;
        if (sclk_fall)
            fp_seen_next = fp_low;
        else if (sclk_rise)
            fp_seen_next = 1'b0;
    end
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            fp_seen_reg <= 1'b0;
        else
            fp_seen_reg <= fp_seen_next;
    end
    // ==========================================
    // per stream input delay and output advance
    genvar s;
    generate
        for (s = 0; s < N_STREAMS; s++)
        begin : g_stream
            wire logic [3:0] nib = in_delay_reg[s / 4][(s % 4) * 4 +: 4];
            logic [2:0] cnt_reg, cnt_next;
            logic arm_reg, arm_next, cap, d_reg, d_next, v_reg, l_reg, l_next;
            // count whole periods, then half on falling edge
            always_comb
            begin
                cnt_next = cnt_reg;
                arm_next = arm_reg;
                cap = 1'b0;
                if (frame_ref)
                begin
                    cnt_next = nib[3:1];
                    arm_next = 1'b1;
                    if (nib[3:1] == 3'h0 && !nib[0])
                        cap = 1'b1;
                end
                else if (arm_reg && sclk_rise && cnt_reg != 3'h0)
                begin
                    cnt_next = cnt_reg - 3'h1;
                    if (cnt_reg == 3'h1 && !nib[0])
                        cap = 1'b1;
                end
                else if (arm_reg && sclk_fall && cnt_reg == 3'h0 && nib[0])
                    cap = 1'b1;
                // one capture per frame, so a stray edge cannot overwrite bit 0
                if (cap)
                    arm_next = 1'b0;
                d_next = cap ? data_s[s] : d_reg;
                // advanced launch on the falling edge that flags the frame
                l_next = adv_bits[s] ? (sclk_fall & fp_low) : frame_ref;
            end
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cnt_reg <= 3'h0;
                    arm_reg <= 1'b0;
                    d_reg <= 1'b0;
                    v_reg <= 1'b0;
                    l_reg <= 1'b0;
                end
                else
                begin
                    cnt_reg <= cnt_next;
                    arm_reg <= arm_next;
                    d_reg <= d_next;
                    v_reg <= cap;
                    l_reg <= l_next;
                end
            end
            assign bit0_data[s] = d_reg;
            assign bit0_valid[s] = v_reg;
            assign out_launch[s] = l_reg;
        end
    endgenerate
    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_req_start;
        state_reg == SOA_IDLE && state_next == SOA_BUSY;
    endsequence
    sequence s_done_up;
        access_reg[`SOA_BIT_DONE] && !access_reg[`SOA_BIT_RD_REQ] && !access_reg[`SOA_BIT_WR_REQ];
    endsequence
    a_done_after_req: assert property (s_req_start |-> ##2 s_done_up)
        else $error("done flag not set after request");
    a_req_self_clear: assert property (s_req_start ##1 1'b1 |=> ~|access_reg[13:12])
        else $error("request bit did not self clear");
    a_done_clear: assert property (wr_take && bus_s2_reg.addr == `SOA_OFS_ACCESS && state_reg == SOA_IDLE
        && bus_s2_reg.wdata[13:12] == 2'b00 |=> !access_reg[`SOA_BIT_DONE])
        else $error("done flag not cleared by request drop");
    a_done_only_hw: assert property ($rose(access_reg[`SOA_BIT_DONE]) |-> $past(state_reg) == SOA_BUSY)
        else $error("done flag set without transfer");
    a_mem_write: assert property (mem_we |=> mem_reg[$past(mem_idx)] == $past(wdata_reg))
        else $error("memory write lost");
    a_meas_half: assert property (rd_active && bus_s2_reg.addr == `SOA_OFS_MEASURE && meas_sel_reg == 5'h00
        |=> bus_rdata[`SOA_BIT_HALF:0] == {!$past(in_delay_reg[0][0]), 6'h00, $past(in_delay_reg[0][3:1])})
        else $error("measured delay encoding wrong");
    a_adv_launch: assert property (sclk_fall && fp_low && adv_bits[2] |=> out_launch[2])
        else $error("advanced launch missing");
    a_norm_launch: assert property (frame_ref && !adv_bits[0] |=> out_launch[0])
        else $error("normal launch missing");
    a_zero_shift: assert property (frame_ref && in_delay_reg[0][3:0] == 4'h0 |=> bit0_valid[0])
        else $error("zero offset did not sample at frame");
    a_xfer_bound: assert property (state_reg == SOA_BUSY |=> state_reg == SOA_IDLE)
        else $error("transfer longer than allowed");
endmodule
`default_nettype wire

// File: tb/soa_cpu_model.sv
// microprocessor model driving the register port pins
`timescale 1ns/1ps
`default_nettype none
module soa_cpu_model (
    // clock
    input wire logic ref_clk,
    // register port pins
    output var soa_pkg::soa_bus_t bus_pins,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rdata_oe
);
    import soa_pkg::*;
    initial
    begin
        bus_pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 16'h0000};
    end
    // ==========================================================
    // write cycle
    // strobe held 5 clocks: pins cross two sync flops first
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == 8'h0B)
            v[15:8] = 8'h00;
        @(posedge ref_clk);
        bus_pins.addr <= a;
        bus_pins.wdata <= v;
        bus_pins.cs_n <= 1'b0;
        bus_pins.wr_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_pins.cs_n <= 1'b1;
        bus_pins.wr_n <= 1'b1;
        @(posedge ref_clk);
        // released lines show the inverse, never a stale value
        bus_pins.addr <= ~a;
        bus_pins.wdata <= ~v;
        repeat (5) @(posedge ref_clk);
    endtask
    // ==========================================================
    // read cycle
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge ref_clk);
        bus_pins.addr <= a;
        bus_pins.cs_n <= 1'b0;
        bus_pins.rd_n <= 1'b0;
        for (int n = 0; n < 10 && !ok; n++)
        begin
            @(posedge ref_clk);
            #1;
            if (bus_rdata_oe === 1'b1)
            begin
                ok = 1'b1;
                d = bus_rdata;
            end
        end
        @(posedge ref_clk);
        bus_pins.cs_n <= 1'b1;
        bus_pins.rd_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        bus_pins.addr <= ~a;
    endtask
endmodule
`default_nettype wire

// File: tb/soa_stream_offset_tb.sv
// self-checking bench for the stream offset and indirect access block
`timescale 1ns/1ps
`default_nettype none
module soa_stream_offset_tb;
    import soa_pkg::*;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} soa_row_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk = 1'b1;
    logic fp_n = 1'b1;
    logic [23:0] pat = 24'hA53C96;
    soa_bus_t bus_pins;
    logic [15:0] bus_rdata;
    logic bus_rdata_oe;
    logic [23:0] bit0_data;
    logic [23:0] bit0_valid;
    logic [23:0] out_launch;
    int n_mismatch = 0;
    int n_compared = 0;
    int tv [24];
    int tl [24];
    // offsets, advance bits, measure select, data, unmapped and read-only places
    soa_row_t rows [9] = '{'{8'h03, 16'h9120, 16'h9120}, '{8'h08, 16'h4000, 16'h4000},
        '{8'h0A, 16'h0004, 16'h0004}, '{8'h0B, 16'h0080, 16'h0080}, '{8'h09, 16'h1800, 16'h1804},
        '{8'h09, 16'hB800, 16'hBA02}, '{8'h0D, 16'h5AC3, 16'h5AC3}, '{8'h1F, 16'hFFFF, 16'h0000},
        '{8'h0E, 16'h1234, 16'h0000}};
    int fs [4] = '{1, 2, 3, 23};
    int fd [4] = '{16, 8, 72, 32};
    logic [15:0] madr [4] = '{16'h00A7, 16'h00C7, 16'h00A8, 16'h0018};
    logic [15:0] mdat [4] = '{16'hBEEF, 16'h1234, 16'h5A5A, 16'hFFFF};
    logic [15:0] mexp [4] = '{16'hBEEF, 16'h1234, 16'h5A5A, 16'h0000};
    logic [7:0] radr [7] = '{8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    logic [15:0] rexp [7] = '{16'h0000, 16'h0000, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    always #5 ref_clk = ~ref_clk;

    soa_stream_offset uut (.ref_clk(ref_clk), .nrst(nrst), .bus_pins(bus_pins), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe), .serial_clk(sclk), .frame_pulse_in_n(fp_n), .serial_stream_pin(pat),
        .bit0_data(bit0_data), .bit0_valid(bit0_valid), .out_launch(out_launch));
    soa_cpu_model cpu (.ref_clk(ref_clk), .bus_pins(bus_pins), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe));

    // ==========================================================
    // helpers
    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
        logic [15:0] d;
        logic ok;
        cpu.read_reg(a, d, ok);
        chk({15'h0000, ok}, 16'h0001, "read answered");
        chk(d, exp, msg);
    endtask
    // check done on one read, then drop the request
    task automatic mem_op(input logic [15:0] req);
        cpu.write_reg(8'h0C, req);
        rd_chk(8'h0C, 16'h4000 | (req & 16'h0FFF), "done set, request self-cleared");
        cpu.write_reg(8'h0C, req & 16'h0FFF);
        rd_chk(8'h0C, req & 16'h0FFF, "done cleared");
    endtask
    // serial clock only runs inside the frame
    task automatic run_frame();
        foreach (tv[s])
        begin
            tv[s] = -1;
            tl[s] = -1;
        end
        @(posedge ref_clk);
        fp_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sclk <= 1'b0;
        repeat (8) @(posedge ref_clk);
        sclk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fp_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        repeat (7)
        begin
            sclk <= 1'b0;
            repeat (8) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (8) @(posedge ref_clk);
        end
    endtask
    // first pulse per stream, sampled mid-cycle where outputs are settled
    int cyc = 0;
    always @(negedge ref_clk)
    begin
        cyc++;
        for (int s = 0; s < 24; s++)
        begin
            if (bit0_valid[s] === 1'b1 && tv[s] < 0)
                tv[s] = cyc;
            if (out_launch[s] === 1'b1 && tl[s] < 0)
                tl[s] = cyc;
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            cpu.write_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e, "register readback");
        end
        $display("register rows done");
        run_frame();
        for (int i = 0; i < 4; i++)
            chk(16'(tv[fs[i]] - tv[0]), 16'(fd[i]), "capture delay");
        chk(16'(tl[0] - tl[2]), 16'h0008, "advance in low register");
        chk(16'(tl[0] - tl[23]), 16'h0008, "advance in high register");
        chk(16'(tl[1] - tl[0]), 16'h0000, "normal alignment");
        for (int s = 0; s < 24; s++)
            chk(16'(bit0_data[s]), 16'(pat[s]), "bit 0 captured");
        $display("frame test done");
        for (int i = 0; i < 4; i++)
        begin
            cpu.write_reg(8'h0D, mdat[i]);
            mem_op(16'h1000 | madr[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            mem_op(16'h2000 | madr[i]);
            rd_chk(8'h0E, mexp[i], "indirect read back");
        end
        cpu.write_reg(8'h0C, 16'h40A7);
        rd_chk(8'h0C, 16'h00A7, "done not writable");
        $display("indirect access test done");
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd_chk(radr[i], rexp[i], "reset value");
        $display("reset test done");
        end_of_test();
    end

    // hang guard: whole run needs well under 5000 clocks
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
